// ---- src/dmt_pkg.sv ----
/*
 * Shared constants and state types for the dual 16-bit multimode timer:
 * APB register offsets, field positions, mode codes and reset values.
 * Assumes a 32-bit APB with byte addresses and one register per word.
 */
package dmt_pkg;

   localparam int DMT_DATA_W = 32;
   localparam int DMT_ADDR_W = 8;
   localparam int DMT_CNT_W = 16;
   localparam int DMT_PRE_W = 4;

   // Register byte offsets
   localparam logic [7:0] DMT_OFF_TMR_X = 8'h00;
   localparam logic [7:0] DMT_OFF_TMR_Y = 8'h04;
   localparam logic [7:0] DMT_OFF_MODE_X = 8'h08;
   localparam logic [7:0] DMT_OFF_MODE_Y = 8'h0c;
   localparam logic [7:0] DMT_OFF_STOP = 8'h10;
   localparam logic [7:0] DMT_OFF_EDGE = 8'h14;
   localparam logic [7:0] DMT_OFF_REQ1 = 8'h18;
   localparam logic [7:0] DMT_OFF_REQ2 = 8'h1c;

   // Mode register fields
   localparam int DMT_MODE_LATCH_ONLY = 3;
   localparam int DMT_MODE_OUT_LVL = 4;
   localparam int DMT_MODE_TRIG_SEL = 5;

   // Operating mode codes in mode bits 2..0
   localparam logic [2:0] DMT_OP_TIMER = 3'h0;
   localparam logic [2:0] DMT_OP_PULSE = 3'h1;
   localparam logic [2:0] DMT_OP_CYCLE = 3'h2;
   localparam logic [2:0] DMT_OP_WIDTH = 3'h3;
   localparam logic [2:0] DMT_OP_WAVE = 3'h4;
   localparam logic [2:0] DMT_OP_ONESHOT = 3'h5;

   // Count source codes in mode bits 7..6
   localparam logic [1:0] DMT_SRC_DIV2 = 2'h0;
   localparam logic [1:0] DMT_SRC_DIV8 = 2'h1;
   localparam logic [1:0] DMT_SRC_DIV16 = 2'h2;
   localparam logic [1:0] DMT_SRC_PIN = 2'h3;

   // Prescaler terminal values
   localparam logic [0:0] DMT_DIV2_TERM = 1'h1;
   localparam logic [2:0] DMT_DIV8_TERM = 3'h7;
   localparam logic [3:0] DMT_DIV16_TERM = 4'hf;

   // Edge polarity and request register bit bases
   localparam int DMT_EDGE_INT_LSB = 0;
   localparam int DMT_EDGE_CNTR_LSB = 2;
   localparam int DMT_REQ2_INT_LSB = 0;
   localparam int DMT_REQ2_MEAS_LSB = 2;

   // Reset and load values
   localparam logic [1:0] DMT_STOP_RESET = 2'h3;
   localparam logic [15:0] DMT_CNT_ONES = 16'hffff;
   localparam logic [15:0] DMT_CNT_ZERO = 16'h0000;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] latch;
      logic [7:0] mode;
      logic out;
      logic active;
   } dmt_chan_s;

   typedef struct packed {
      dmt_chan_s [1:0] ch;
      logic [1:0] timer_pair_stop_control;
      logic [3:0] edge_polarity_select;
      logic [1:0] interrupt_request_first;
      logic [3:0] interrupt_request_second;
      logic [3:0] presc;
      logic [1:0] cntr_s1;
      logic [1:0] cntr_s2;
      logic [1:0] cntr_s3;
      logic [1:0] irq_s1;
      logic [1:0] irq_s2;
      logic [1:0] irq_s3;
      logic [31:0] prdata;
      logic pslverr;
   } dmt_state_s;

endpackage

// ---- src/dmt_timer.sv ----
/*
 * Dual 16-bit multimode count-down timer (X and Y) with an APB slave.
 * Modes: timer/event count, pulse output, pulse cycle and pulse width
 * measurement, programmable waveform and programmable one-shot.
 * Assumes: pclk at 10 MHz, counter and trigger pins asynchronous to pclk,
 * a separate interrupt controller reading the request bit outputs.
 */
`timescale 1ns/1ps

module dmt_timer
   import dmt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [DMT_ADDR_W-1:0] paddr,
   input wire logic [DMT_DATA_W-1:0] pwdata,
   output logic [DMT_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic counter_pin_0_in,
   output logic counter_pin_0_out,
   output logic counter_pin_0_oe,
   input wire logic counter_pin_1_in,
   output logic counter_pin_1_out,
   output logic counter_pin_1_oe,
   input wire logic ext_irq_pin_0,
   input wire logic ext_irq_pin_1,
   output logic [1:0] interrupt_request_first,
   output logic [3:0] interrupt_request_second
);

   // All state of the block lives in one packed struct.
   // The combinational process below builds next_st from st and the
   // inputs; the single clocked process copies it across on each edge.
   // Keeping every field in one place makes reset and capture uniform,
   // at the cost of a wide register that the tools must split again.
   // Field groups:
   //  - per-channel counter, latch, mode, pin level and trigger state
   //  - shared stop, polarity and request registers
   //  - prescaler and the pin synchroniser stages
   //  - APB read data and error flag, prepared in the setup cycle
   dmt_state_s st;
   dmt_state_s next_st;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic: pins, prescaler, both timers and the register file
   always_comb begin
      logic [1:0] cntr_rise;
      logic [1:0] cntr_fall;
      logic [1:0] irq_rise;
      logic [1:0] irq_fall;
      logic en2;
      logic en8;
      logic en16;
      logic setup;
      logic wr;
      logic [1:0] set1;
      logic [3:0] set2;
      logic [2:0] op;
      logic [2:0] new_op;
      logic run;
      logic cedge;
      logic iedge;
      logic pulse;
      logic gate;
      logic tick;
      logic meas;
      logic int_hit;
      logic start_hit;
      logic done_hit;
      logic hit_ok;
      logic [31:0] rdata;
      cntr_rise = 2'h0;
      cntr_fall = 2'h0;
      irq_rise = 2'h0;
      irq_fall = 2'h0;
      en2 = 1'b0;
      en8 = 1'b0;
      en16 = 1'b0;
      setup = 1'b0;
      wr = 1'b0;
      set1 = 2'h0;
      set2 = 4'h0;
      op = DMT_OP_TIMER;
      new_op = DMT_OP_TIMER;
      run = 1'b0;
      cedge = 1'b0;
      iedge = 1'b0;
      pulse = 1'b0;
      gate = 1'b0;
      tick = 1'b0;
      meas = 1'b0;
      int_hit = 1'b0;
      start_hit = 1'b0;
      done_hit = 1'b0;
      hit_ok = 1'b0;
      rdata = 32'h0000_0000;
      next_st = st;

      // Pins are asynchronous to pclk, so nothing reads stage one but
      // stage two. An edge is seen three clock edges after the pin moves,
      // and a pin level need only stand across one full clock to be seen.
      // Shorter glitches may be missed; that is a limitation to document.
      // Two-stage synchronisers; edges come from stages two and three only
      next_st.cntr_s1 = {counter_pin_1_in, counter_pin_0_in};
      next_st.cntr_s2 = st.cntr_s1;
      next_st.cntr_s3 = st.cntr_s2;
      next_st.irq_s1 = {ext_irq_pin_1, ext_irq_pin_0};
      next_st.irq_s2 = st.irq_s1;
      next_st.irq_s3 = st.irq_s2;
      cntr_rise = st.cntr_s2 & ~st.cntr_s3;
      cntr_fall = ~st.cntr_s2 & st.cntr_s3;
      irq_rise = st.irq_s2 & ~st.irq_s3;
      irq_fall = ~st.irq_s2 & st.irq_s3;

      // One clock only: the slower count rates are enable pulses.
      // The prescaler is not cleared when a timer starts, so the first
      // count after start comes up to one full divider period later.
      // Free-running prescaler; each tap is a one-cycle enable
      next_st.presc = st.presc + 4'h1;
      en2 = (st.presc[0:0] == DMT_DIV2_TERM);
      en8 = (st.presc[2:0] == DMT_DIV8_TERM);
      en16 = (st.presc == DMT_DIV16_TERM);

      setup = psel & ~penable;
      wr = psel & penable & pwrite;

      // The loop runs once per timer; index 0 is timer X, 1 is timer Y.
      // Order inside the loop sets priority between same-cycle events:
      //  1. trigger edges set requests and arm the triggered modes
      //  2. the count pulse decrements or underflows
      //  3. measurement edges overwrite the counter last
      // A capture therefore beats an underflow in the same cycle, so a
      // measurement value is never lost to a coincident reload.
      // Register writes later in the process beat all of these except request setting (a new event wins) and timer writes during a running measurement.
      // Per-timer counting, measurement and output behaviour
      for (int i = 0; i < 2; i++) begin
         op = st.ch[i].mode[2:0];
         run = ~st.timer_pair_stop_control[i];
         cedge = st.edge_polarity_select[DMT_EDGE_CNTR_LSB + i];
         iedge = st.edge_polarity_select[DMT_EDGE_INT_LSB + i];
         meas = (op == DMT_OP_CYCLE) || (op == DMT_OP_WIDTH);
         int_hit = iedge ? irq_rise[i] : irq_fall[i];
         // Count pulse select
         case (st.ch[i].mode[7:6])
            DMT_SRC_DIV2: pulse = en2;
            DMT_SRC_DIV8: pulse = en8;
            DMT_SRC_DIV16: pulse = en16;
            DMT_SRC_PIN: pulse = cedge ? cntr_fall[i] : cntr_rise[i];
            default: pulse = 1'b0;
         endcase
         // Triggered modes count only while a start or shot is in progress
         case (op)
            DMT_OP_WAVE: gate = ~st.ch[i].mode[DMT_MODE_TRIG_SEL] | st.ch[i].active;
            DMT_OP_ONESHOT: gate = st.ch[i].active;
            default: gate = 1'b1;
         endcase
         tick = run & gate & pulse;
         if (!run) begin
            next_st.ch[i].active = 1'b0;
         end
         // Trigger pin edges
         if ((op == DMT_OP_WAVE || op == DMT_OP_ONESHOT) && int_hit) begin
            set2[DMT_REQ2_INT_LSB + i] = 1'b1;
         end
         if (op == DMT_OP_WAVE && st.ch[i].mode[DMT_MODE_TRIG_SEL] && run && int_hit) begin
            next_st.ch[i].active = 1'b1;
         end
         if (op == DMT_OP_ONESHOT && run && int_hit) begin
            next_st.ch[i].active = 1'b1;
            next_st.ch[i].out = ~cedge;
         end
         // Count down and underflow
         if (tick) begin
            if (st.ch[i].cnt == DMT_CNT_ZERO) begin
               set1[i] = 1'b1;
               next_st.ch[i].cnt = meas ? DMT_CNT_ONES : st.ch[i].latch;
               case (op)
                  DMT_OP_PULSE: next_st.ch[i].out = ~st.ch[i].out;
                  DMT_OP_WAVE: next_st.ch[i].out = st.ch[i].mode[DMT_MODE_OUT_LVL];
                  DMT_OP_ONESHOT: begin
                     next_st.ch[i].out = cedge;
                     next_st.ch[i].active = 1'b0;
                  end
                  default: next_st.ch[i].out = st.ch[i].out;
               endcase
            end else begin
               next_st.ch[i].cnt = st.ch[i].cnt - 16'h0001;
            end
         end
         // Measurement edges; a capture edge wins over an underflow
         start_hit = 1'b0;
         done_hit = 1'b0;
         if (op == DMT_OP_CYCLE) begin
            done_hit = cedge ? cntr_rise[i] : cntr_fall[i];
         end else if (op == DMT_OP_WIDTH) begin
            start_hit = cedge ? cntr_fall[i] : cntr_rise[i];
            done_hit = cedge ? cntr_rise[i] : cntr_fall[i];
         end
         if (run && start_hit) begin
            next_st.ch[i].cnt = DMT_CNT_ONES;
         end
         if (run && done_hit) begin
            next_st.ch[i].latch = ~st.ch[i].cnt;
            next_st.ch[i].cnt = DMT_CNT_ONES;
            set2[DMT_REQ2_MEAS_LSB + i] = 1'b1;
         end
      end

      // A write takes effect only at the edge ending the access cycle.
      // Unmapped write addresses fall to the default branch and change
      // nothing; the error flag was already prepared in setup.
      // Latch-only writes leave the counter alone, so a write landing on
      // an underflow edge reloads the old latch value, not the new one.
      // Register writes, taken in the access phase; they win over counting
      if (wr) begin
         case (paddr)
            DMT_OFF_TMR_X, DMT_OFF_TMR_Y: begin
               for (int i = 0; i < 2; i++) begin
                  op = st.ch[i].mode[2:0];
                  run = ~st.timer_pair_stop_control[i];
                  meas = (op == DMT_OP_CYCLE) || (op == DMT_OP_WIDTH);
                  hit_ok = (paddr == (i == 0 ? DMT_OFF_TMR_X : DMT_OFF_TMR_Y));
                  // Running measurement owns the latch; a write would corrupt it
                  if (hit_ok && !(meas && run)) begin
                     next_st.ch[i].latch = pwdata[15:0];
                     if (!st.ch[i].mode[DMT_MODE_LATCH_ONLY]) begin
                        next_st.ch[i].cnt = pwdata[15:0];
                     end
                     if (op == DMT_OP_PULSE && !run) begin
                        next_st.ch[i].out =
                           st.edge_polarity_select[DMT_EDGE_CNTR_LSB + i];
                     end
                  end
               end
            end
            DMT_OFF_MODE_X, DMT_OFF_MODE_Y: begin
               for (int i = 0; i < 2; i++) begin
                  hit_ok = (paddr == (i == 0 ? DMT_OFF_MODE_X : DMT_OFF_MODE_Y));
                  new_op = pwdata[2:0];
                  if (hit_ok) begin
                     next_st.ch[i].mode = pwdata[7:0];
                     next_st.ch[i].active = 1'b0;
                     if (new_op == DMT_OP_ONESHOT) begin
                        next_st.ch[i].out =
                           st.edge_polarity_select[DMT_EDGE_CNTR_LSB + i];
                     end
                  end
               end
            end
            DMT_OFF_STOP: next_st.timer_pair_stop_control = pwdata[1:0];
            DMT_OFF_EDGE: begin
               next_st.edge_polarity_select = pwdata[3:0];
               for (int i = 0; i < 2; i++) begin
                  op = st.ch[i].mode[2:0];
                  run = ~st.timer_pair_stop_control[i];
                  if (op == DMT_OP_PULSE && run && (pwdata[DMT_EDGE_CNTR_LSB + i] !=
                        st.edge_polarity_select[DMT_EDGE_CNTR_LSB + i])) begin
                     next_st.ch[i].out = ~next_st.ch[i].out;
                  end
               end
            end
            default: next_st.pslverr = st.pslverr;
         endcase
      end

      // Writing 1 keeps a bit, so software clears one flag safely
      // without a read-modify-write race against the hardware.
      // An event in the clear cycle wins so no request is ever lost.
      // Request bits: software clears by writing 0, a new event wins
      next_st.interrupt_request_first = ((wr && paddr == DMT_OFF_REQ1) ?
         (st.interrupt_request_first & pwdata[1:0]) : st.interrupt_request_first) | set1;
      next_st.interrupt_request_second = ((wr && paddr == DMT_OFF_REQ2) ?
         (st.interrupt_request_second & pwdata[3:0]) : st.interrupt_request_second) | set2;

      // Registering read data keeps prdata off a long decode path, and
      // lets pready stay high with no wait state.
      // The value read is that of the setup edge, one cycle before the
      // access edge; a count in between is not reflected.
      // Read data and error are prepared in the setup phase
      if (setup) begin
         next_st.pslverr = 1'b0;
         case (paddr)
            DMT_OFF_TMR_X, DMT_OFF_TMR_Y: begin
               for (int i = 0; i < 2; i++) begin
                  op = st.ch[i].mode[2:0];
                  meas = (op == DMT_OP_CYCLE) || (op == DMT_OP_WIDTH);
                  hit_ok = (paddr == (i == 0 ? DMT_OFF_TMR_X : DMT_OFF_TMR_Y));
                  if (hit_ok && !meas) begin
                     rdata = {16'h0000, st.ch[i].cnt};
                  end
               end
            end
            DMT_OFF_MODE_X: rdata = {24'h00_0000, st.ch[0].mode};
            DMT_OFF_MODE_Y: rdata = {24'h00_0000, st.ch[1].mode};
            DMT_OFF_STOP: rdata = {30'h0000_0000, st.timer_pair_stop_control};
            DMT_OFF_EDGE: rdata = {28'h000_0000, st.edge_polarity_select};
            DMT_OFF_REQ1: rdata = {30'h0000_0000, st.interrupt_request_first};
            DMT_OFF_REQ2: rdata = {28'h000_0000, st.interrupt_request_second};
            default: next_st.pslverr = 1'b1;
         endcase
         next_st.prdata = rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset clears everything except the stop bits, which hold both
   // timers stopped until software has loaded them.
   // State register; constants only under reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.timer_pair_stop_control <= DMT_STOP_RESET;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin levels come straight from flip-flops, so they never glitch.
   // The enable follows the mode alone; the stop bit does not release
   // the pin, which would otherwise float between one-shot pulses.
   // Outputs; the pin is driven only in the three output modes
   assign prdata = st.prdata;
   assign pready = 1'b1; // Zero wait states keep the slave simple
   assign pslverr = st.pslverr & psel & penable;
   assign counter_pin_0_out = st.ch[0].out;
   assign counter_pin_1_out = st.ch[1].out;
   assign counter_pin_0_oe = (st.ch[0].mode[2:0] == DMT_OP_PULSE) ||
      (st.ch[0].mode[2:0] == DMT_OP_WAVE) || (st.ch[0].mode[2:0] == DMT_OP_ONESHOT);
   assign counter_pin_1_oe = (st.ch[1].mode[2:0] == DMT_OP_PULSE) ||
      (st.ch[1].mode[2:0] == DMT_OP_WAVE) || (st.ch[1].mode[2:0] == DMT_OP_ONESHOT);
   assign interrupt_request_first = st.interrupt_request_first;
   assign interrupt_request_second = st.interrupt_request_second;

endmodule // dmt_timer

// ---- verification/dmt_pins_model.sv ----
/* Far-side model: pulse sources on the counter and trigger pins, and the
   wire resolution where the block drives a counter pin. One caller only. */
`timescale 1ns/1ps
module dmt_pins_model (
   input wire logic pclk,
   input wire logic [1:0] cnt_out,
   input wire logic [1:0] cnt_oe,
   output logic [1:0] cnt_in,
   output logic [1:0] irq
);
   logic [3:0] src = 4'h0;
   // The block's driver wins where enabled, else the outside source
   assign cnt_in = (cnt_oe & cnt_out) | (~cnt_oe & src[1:0]);
   assign irq = src[3:2];
   // Change just after an edge, then hold well past the two-flop sampler
   task automatic drive(input int idx, input logic v);
      @(posedge pclk);
      src[idx] <= v;
      repeat (5) @(posedge pclk);
   endtask
endmodule // dmt_pins_model

// ---- verification/dmt_timer_assertions.sv ----
/* Checker for dmt_timer: shadows the timer X controls written over APB
   and ties pin and request outputs to them. Sees only top-level ports. */
`timescale 1ns/1ps
module dmt_timer_assertions
   import dmt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [DMT_ADDR_W-1:0] paddr,
   input wire logic [DMT_DATA_W-1:0] pwdata,
   input wire logic [DMT_DATA_W-1:0] prdata,
   input wire logic counter_pin_0_out,
   input wire logic counter_pin_0_oe,
   input wire logic ext_irq_pin_0,
   input wire logic [1:0] interrupt_request_first,
   input wire logic [3:0] interrupt_request_second
);
   logic wr, clr1, stop_x, out;
   logic [7:0] mode_x;
   logic [3:0] edge_r;
   logic [2:0] op;
   // Committed write strobes
   assign wr = psel && penable && pwrite;
   assign clr1 = wr && paddr == DMT_OFF_REQ1 && !pwdata[0];
   assign op = mode_x[2:0];
   assign out = counter_pin_0_out;
   // Shadow of X controls, updated on the same edge as the block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_x <= 8'h00;
         edge_r <= 4'h0;
         stop_x <= 1'h1;
      end else if (wr) begin
         if (paddr == DMT_OFF_MODE_X) mode_x <= pwdata[7:0];
         if (paddr == DMT_OFF_EDGE) edge_r <= pwdata[3:0];
         if (paddr == DMT_OFF_STOP) stop_x <= pwdata[0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   chk_oe_decode: assert property (counter_pin_0_oe == (op == 3'h1 || op == 3'h4 || op == 3'h5))
      else $error("pin enable does not follow mode");
   chk_pulse_force: assert property (wr && paddr == DMT_OFF_TMR_X && op == DMT_OP_PULSE
      && stop_x |-> ##[1:2] out == edge_r[2]) else $error("pulse level not forced");
   chk_pulse_flip: assert property (wr && paddr == DMT_OFF_EDGE && op == DMT_OP_PULSE && !stop_x
      && pwdata[2] != edge_r[2] |-> ##[1:2] out != $past(out)) else $error("pulse not inverted");
   chk_pulse_toggle: assert property (op == DMT_OP_PULSE && $rose(interrupt_request_first[0])
      |-> ##[0:1] out != $past(out)) else $error("pulse not toggled at underflow");
   chk_wave_level: assert property (op == DMT_OP_WAVE && $rose(interrupt_request_first[0])
      |-> ##[0:1] out == mode_x[4]) else $error("wave level wrong");
   chk_shot_idle: assert property (wr && paddr == DMT_OFF_MODE_X && pwdata[2:0] == DMT_OP_ONESHOT
      |-> ##[1:2] out == edge_r[2]) else $error("one-shot idle level wrong");
   chk_shot_stopped: assert property (op == DMT_OP_ONESHOT && stop_x && !wr && !$past(wr)
      |=> $stable(out)) else $error("one-shot moved while stopped");
   chk_meas_read: assert property (psel && penable && !pwrite && paddr == DMT_OFF_TMR_X
      && (op == DMT_OP_CYCLE || op == DMT_OP_WIDTH) |-> prdata == 32'h0) else $error("timer readable");
   chk_req_clear: assert property ($fell(interrupt_request_first[0]) |-> $past(clr1))
      else $error("request dropped without a clear");
   chk_trig_req: assert property ((op == DMT_OP_WAVE || op == DMT_OP_ONESHOT) && !edge_r[0]
      && $fell(ext_irq_pin_0) |-> ##[1:5] interrupt_request_second[0]) else $error("no trigger request");
endmodule // dmt_timer_assertions

bind dmt_timer dmt_timer_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .counter_pin_0_out, .counter_pin_0_oe, .ext_irq_pin_0,
   .interrupt_request_first, .interrupt_request_second);

// ---- verification/dmt_timer_bench.sv ----
/* Bench for dmt_timer: APB master tasks and one task per test.
   Assumes the pin model and the bound checker. */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module dmt_timer_bench
   import dmt_pkg::*;
;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err;
   logic [1:0] cin, cout, coe, irq, req1;
   logic [3:0] req2;
   int ticks, num_errors = 0, check_count = 0;
   // 10 MHz clock
   always #50 pclk = ~pclk;
   dmt_timer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .counter_pin_0_in(cin[0]), .counter_pin_0_out(cout[0]),
      .counter_pin_0_oe(coe[0]), .counter_pin_1_in(cin[1]), .counter_pin_1_out(cout[1]),
      .counter_pin_1_oe(coe[1]), .ext_irq_pin_0(irq[0]), .ext_irq_pin_1(irq[1]),
      .interrupt_request_first(req1), .interrupt_request_second(req2));
   dmt_pins_model u_pins (.pclk, .cnt_out(cout), .cnt_oe(coe), .cnt_in(cin), .irq(irq));
   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic hang();
      num_errors++;
      $display("[ERR] %0t wait ran out", $time);
      summarize();
   endtask
   // One transfer; the answer is awaited, never assumed
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) hang();
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      repeat (2) @(negedge pclk);
   endtask
   task automatic put(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic get(input logic [7:0] a);
      apb(1'h0, a, 32'h0);
   endtask
   task automatic wait_uf();
      ticks = 0;
      while (req1[0] !== 1'h1 && ticks < 3000) begin
         @(posedge pclk);
         ticks++;
      end
      if (ticks >= 3000) hang();
      repeat (2) @(negedge pclk);
   endtask
   // Load the timer, clear the underflow requests and start X
   task automatic arm(input logic [31:0] t);
      put(DMT_OFF_TMR_X, t);
      put(DMT_OFF_REQ1, 32'h0);
      put(DMT_OFF_STOP, 32'h2);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      get(DMT_OFF_STOP);
      `CHK(rd[1:0], DMT_STOP_RESET)
      put(DMT_OFF_TMR_X, 32'h5);
      put(DMT_OFF_MODE_X, 32'h8);
      put(DMT_OFF_TMR_X, 32'h9);
      get(DMT_OFF_TMR_X);
      `CHK(rd[15:0], 16'h0005)
      get(8'h20);
      `CHK(err, 1'h1)
      for (int op = 0; op < 6; op++) begin
         put(DMT_OFF_MODE_X, op);
         `CHK(coe[0], (op == 1 || op >= 4))
      end
      $display("regs test done");
   endtask
   task automatic t_div();
      int dv [3] = '{2, 8, 16};
      for (int i = 0; i < 3; i++) begin
         put(DMT_OFF_STOP, 32'h3);
         put(DMT_OFF_MODE_X, i << 6);
         arm(32'h3);
         wait_uf();
         `CHK(ticks >= 3 * dv[i] && ticks <= 4 * dv[i] + 3, 1'h1)
         get(DMT_OFF_TMR_X);
         `CHK(rd[15:0] <= 16'h0003, 1'h1)
      end
      $display("divider test done");
   endtask
   task automatic t_event();
      for (int p = 0; p < 2; p++) begin
         put(DMT_OFF_STOP, 32'h3);
         put(DMT_OFF_MODE_X, {DMT_SRC_PIN, 6'h0});
         put(DMT_OFF_EDGE, p << 2);
         arm(32'h1);
         u_pins.drive(0, 1'h1);
         u_pins.drive(0, 1'h0);
         u_pins.drive(0, 1'h1);
         `CHK(req1[0], p == 0)
         u_pins.drive(0, 1'h0);
         `CHK(req1[0], 1'h1)
      end
      $display("event test done");
   endtask
   task automatic t_pulse();
      put(DMT_OFF_STOP, 32'h3);
      put(DMT_OFF_MODE_X, DMT_OP_PULSE);
      put(DMT_OFF_EDGE, 32'h4);
      arm(32'd20);
      `CHK(cout[0], 1'h1)
      wait_uf();
      `CHK(cout[0], 1'h0)
      put(DMT_OFF_EDGE, 32'h0);
      `CHK(cout[0], 1'h1)
      $display("pulse test done");
   endtask
   // Pin rise, fall, rise: fall ends a measurement unless polarity is 1
   task automatic t_meas();
      for (int k = 0; k < 4; k++) begin
         put(DMT_OFF_STOP, 32'h3);
         u_pins.drive(0, 1'h0);
         put(DMT_OFF_MODE_X, DMT_OP_CYCLE + k[1]);
         put(DMT_OFF_EDGE, {k[0], 2'h0});
         arm(32'hffff);
         u_pins.drive(0, 1'h1);
         put(DMT_OFF_REQ2, 32'h0);
         u_pins.drive(0, 1'h0);
         `CHK(req2[2], !k[0])
         put(DMT_OFF_REQ2, 32'h0);
         u_pins.drive(0, 1'h1);
         `CHK(req2[2], k[0])
         get(DMT_OFF_TMR_X);
         `CHK(rd, 32'h0)
      end
      $display("measure test done");
   endtask
   task automatic t_shot();
      for (int p = 0; p < 2; p++) begin
         put(DMT_OFF_STOP, 32'h3);
         put(DMT_OFF_MODE_X, 32'h0);
         put(DMT_OFF_EDGE, {p[0], 1'h0, p[0]});
         put(DMT_OFF_MODE_X, DMT_OP_ONESHOT);
         `CHK(cout[0], p[0])
         put(DMT_OFF_REQ2, 32'h0);
         u_pins.drive(2, 1'h1);
         u_pins.drive(2, 1'h0);
         `CHK(cout[0], p[0])
         `CHK(req2[0], 1'h1)
         arm(32'd40);
         u_pins.drive(2, 1'h1);
         `CHK(cout[0], 1'h0)
         u_pins.drive(2, 1'h0);
         `CHK(cout[0], !p[0])
         wait_uf();
         `CHK(cout[0], p[0])
      end
      $display("one-shot test done");
   endtask
   task automatic t_wave();
      put(DMT_OFF_STOP, 32'h3);
      put(DMT_OFF_MODE_X, 32'h24);
      put(DMT_OFF_EDGE, 32'h1);
      arm(32'h3);
      repeat (30) @(posedge pclk);
      `CHK(req1[0], 1'h0)
      u_pins.drive(2, 1'h1);
      wait_uf();
      `CHK(cout[0], 1'h0)
      put(DMT_OFF_MODE_X, 32'h14);
      put(DMT_OFF_REQ1, 32'h0);
      wait_uf();
      `CHK(cout[0], 1'h1)
      $display("wave test done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Reset for 10 cycles, then the tests in turn
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      t_regs();
      t_div();
      t_event();
      t_pulse();
      t_meas();
      t_shot();
      t_wave();
      summarize();
   end
endmodule // dmt_timer_bench
